// file: tcm_pkg.sv
// Purpose: constants and types for the period timer and unit mode control
// Assumes: registers are one aligned 32-bit word each, data in low 8 bits
// Notes: printed offsets are register indices; byte address is four times
// Functional notes
// - scaler counters clear on count/control write, reset
// - control write keeps the count value
// - export pre-postscaler match pulse to serial port
// - count up, wrap after limit; limit resets FFh
// - prescale one, four or sixteen by low bits
// - 4-bit postscaler sets the period match flag
// - run bit clear stops counting
// - one 16-bit unit value register
// - value reached as low and high bytes
// - capture/compare use 16-bit timer, PWM 8-bit
// - special-event match: flag, timer reset, converter start
// - control bits 5:4 are PWM duty LSbs
// - control bits 7:6 read as zero
// - software-interrupt match only sets flag
package tcm_pkg;
    localparam logic [7:0] IDX_FLAGS   = 8'h0C;
    localparam logic [7:0] IDX_COUNT   = 8'h11;
    localparam logic [7:0] IDX_CONTROL = 8'h12;
    localparam logic [7:0] IDX_VAL_LO  = 8'h15;
    localparam logic [7:0] IDX_VAL_HI  = 8'h16;
    localparam logic [7:0] IDX_MODE    = 8'h17;
    localparam logic [7:0] IDX_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_LIMIT   = 8'h92;
    localparam int         BIT_UNIT_EV = 2;
    localparam int         BIT_MATCH   = 1;
    localparam logic [7:0] RST_LIMIT   = 8'hFF;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] MASK_CTRL   = 8'h7F;
    localparam logic [7:0] MASK_MODE   = 8'h3F;
    localparam logic [7:0] MASK_FLAGS  = 8'h06;
    localparam logic [3:0] M_OFF       = 4'h0;
    localparam logic [3:0] M_CAP_FALL  = 4'h4;
    localparam logic [3:0] M_CAP_RISE  = 4'h5;
    localparam logic [3:0] M_CAP_4     = 4'h6;
    localparam logic [3:0] M_CAP_16    = 4'h7;
    localparam logic [3:0] M_CMP_SET   = 4'h8;
    localparam logic [3:0] M_CMP_CLR   = 4'h9;
    localparam logic [3:0] M_CMP_SW    = 4'hA;
    localparam logic [3:0] M_CMP_TRIG  = 4'hB;
    localparam logic [1:0] INST_DIV    = 2'h3;

    typedef struct packed {
        logic [3:0] postscale;
        logic       run;
        logic [1:0] prescale;
    } tcm_ctrl_s;

    typedef struct packed {
        logic       sel;
        logic       write;
        logic [7:0] index;
    } tcm_acc_s;
endpackage : tcm_pkg

// file: tcm_timer_unit.sv
// Purpose: period timer with scalers and the unit mode control, AHB-Lite
// Assumes: one clock; the 16-bit timer and capture pin come from outside
// Notes: zero-wait-state slave; the instruction tick is hclk divided by four
//
// The implementer's own choice: register access over AHB-Lite.
module tcm_timer_unit
    import tcm_pkg::*;
(
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // sixteen-bit timer and capture pin
    input  wire logic [15:0] sixteen_bit_timer_count,
    input  wire logic        capture_pin,
    // events out
    output logic             period_match_pulse,
    output logic             timer16_reset,
    output logic             converter_start,
    output logic             unit_pin,
    output logic             irq
);
    tcm_ctrl_s   ctrl;
    tcm_acc_s    acc;
    logic [7:0]  count;
    logic [7:0]  limit;
    logic [7:0]  mode;
    logic [15:0] unit_value;
    logic [1:0]  duty_latch;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [1:0]  inst_div;
    logic [3:0]  pre_cnt;
    logic [3:0]  post_cnt;
    logic [3:0]  cap_cnt;
    logic [9:0]  pwm_cnt;
    logic [2:0]  cap_sync;
    logic        cap_level;
    logic        cmp_hit_d;
    logic [7:0]  wdata;
    logic        wr;
    logic        tick;
    logic        step;
    logic        wrap;
    logic        post_ovf;
    logic        cap_ev;
    logic        cmp_hit;
    logic        cmp_ev;
    logic        pwm_mode;
    logic        wr_count;
    logic        wr_ctrl;

    function automatic logic hit(input logic [7:0] i);
        hit = wr && (acc.index == i);
    endfunction : hit

    function automatic logic [3:0] pre_limit(input logic [1:0] s);
        pre_limit = s[1] ? 4'hF : (s[0] ? 4'h3 : 4'h0);
    endfunction : pre_limit

    assign wdata    = hwdata[7:0];
    assign wr       = acc.sel && acc.write && clk_en;
    assign wr_count = hit(IDX_COUNT);
    assign wr_ctrl  = hit(IDX_CONTROL);
    assign tick     = clk_en && (inst_div == INST_DIV);
    assign step     = tick && ctrl.run && (pre_cnt == pre_limit(ctrl.prescale));
    assign wrap     = step && (count == limit);
    assign post_ovf = wrap && (post_cnt == ctrl.postscale);
    assign pwm_mode = (mode[3:2] == 2'b11);

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            acc <= '0;
        else if (clk_en && hready)
        begin
            acc.sel   <= hsel && htrans[1];
            acc.write <= hwrite;
            acc.index <= haddr[9:2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= '0;
        else if (clk_en && hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[9:2])
                IDX_FLAGS:   hrdata <= {24'h0, flags};
                IDX_ENABLES: hrdata <= {24'h0, enables};
                IDX_COUNT:   hrdata <= {24'h0, count};
                IDX_CONTROL: hrdata <= {25'h0, ctrl};
                IDX_LIMIT:   hrdata <= {24'h0, limit};
                IDX_MODE:    hrdata <= {24'h0, mode & MASK_MODE};
                IDX_VAL_LO:  hrdata <= {24'h0, unit_value[7:0]};
                IDX_VAL_HI:  hrdata <= {24'h0, unit_value[15:8]};
                default:     hrdata <= '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            inst_div <= '0;
        else if (clk_en)
            inst_div <= inst_div + 2'h1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl  <= '0;
            limit <= RST_LIMIT;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= tcm_ctrl_s'(wdata[6:0]);
            if (hit(IDX_LIMIT))
                limit <= wdata;
        end
    end

    // count; a control write leaves it alone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count <= RST_ZERO;
        else if (wr_count)
            count <= wdata;
        else if (wrap)
            count <= RST_ZERO;
        else if (step)
            count <= count + 8'h01;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_cnt  <= '0;
            post_cnt <= '0;
        end
        else if (wr_count || wr_ctrl)
        begin
            pre_cnt  <= '0;
            post_cnt <= '0;
        end
        else
        begin
            if (tick && ctrl.run)
                pre_cnt <= step ? 4'h0 : pre_cnt + 4'h1;
            if (wrap)
                post_cnt <= post_ovf ? 4'h0 : post_cnt + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            period_match_pulse <= 1'b0;
        else if (clk_en)
            period_match_pulse <= wrap;
    end

    // capture pin synchroniser, change counted when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cap_sync  <= '0;
            cap_level <= 1'b0;
        end
        else if (clk_en)
        begin
            cap_sync <= {cap_sync[1:0], capture_pin};
            if (cap_sync[2] == cap_sync[1])
                cap_level <= cap_sync[2];
        end
    end

    always_comb
    begin
        cap_ev = 1'b0;
        if (clk_en && (cap_sync[2] == cap_sync[1])
            && (cap_sync[2] != cap_level))
        begin
            unique case (mode[3:0])
                M_CAP_FALL: cap_ev = !cap_sync[2];
                M_CAP_RISE: cap_ev = cap_sync[2];
                M_CAP_4:    cap_ev = cap_sync[2] && (cap_cnt[1:0] == 2'h3);
                M_CAP_16:   cap_ev = cap_sync[2] && (cap_cnt == 4'hF);
                default:    cap_ev = 1'b0;
            endcase
        end
    end

    // capture prescaler, cleared outside capture modes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cap_cnt <= '0;
        else if (clk_en && mode[3:2] != 2'b01)
            cap_cnt <= '0;
        else if (clk_en && cap_sync[2] && !cap_level
                 && (cap_sync[2] == cap_sync[1]))
            cap_cnt <= cap_cnt + 4'h1;
    end

    // compare on the 16-bit timer, one event per match entry
    assign cmp_hit = (mode[3:2] == 2'b10)
                     && (unit_value == sixteen_bit_timer_count);
    assign cmp_ev  = clk_en && cmp_hit && !cmp_hit_d;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cmp_hit_d <= 1'b0;
        else if (clk_en)
            cmp_hit_d <= cmp_hit;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode <= RST_ZERO;
        else if (hit(IDX_MODE))
            mode <= wdata & MASK_MODE;
    end

    // unit value: whole value captured; low byte written, high byte written outside PWM or PWM latch
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            unit_value <= '0;
            duty_latch <= '0;
        end
        else if (cap_ev)
            unit_value <= sixteen_bit_timer_count;
        else
        begin
            if (hit(IDX_VAL_LO))
                unit_value[7:0] <= wdata;
            if (pwm_mode && wrap)
            begin
                unit_value[15:8] <= unit_value[7:0];
                duty_latch       <= mode[5:4];
            end
            else if (hit(IDX_VAL_HI) && !pwm_mode)
                unit_value[15:8] <= wdata;
        end
    end

    // pwm fine counter on the 8-bit timer plus two sub bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pwm_cnt <= '0;
        else if (wrap || wr_count)
            pwm_cnt <= '0;
        else if (clk_en && ctrl.run)
            pwm_cnt <= pwm_cnt + 10'h001;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            unit_pin <= 1'b0;
        else if (clk_en && mode[3:0] == M_OFF)
            unit_pin <= 1'b0;
        else if (clk_en && pwm_mode)
        begin
            if (wrap)
                unit_pin <= (unit_value[7:0] != 8'h00)
                            || (mode[5:4] != 2'b00);
            else if (pwm_cnt[9:0] == {unit_value[15:8], duty_latch})
                unit_pin <= 1'b0;
        end
        else if (cmp_ev && mode[3:0] == M_CMP_SET)
            unit_pin <= 1'b1;
        else if (cmp_ev && mode[3:0] == M_CMP_CLR)
            unit_pin <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer16_reset   <= 1'b0;
            converter_start <= 1'b0;
        end
        else if (clk_en)
        begin
            timer16_reset   <= cmp_ev && (mode[3:0] == M_CMP_TRIG);
            converter_start <= cmp_ev && (mode[3:0] == M_CMP_TRIG);
        end
    end

    // sticky flags: write one clears, a new event wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flags   <= RST_ZERO;
            enables <= RST_ZERO;
        end
        else
        begin
            if (hit(IDX_ENABLES))
                enables <= wdata & MASK_FLAGS;
            if (hit(IDX_FLAGS))
                flags <= flags & ~wdata & MASK_FLAGS;
            if (post_ovf)
                flags[BIT_MATCH] <= 1'b1;
            if (cap_ev || cmp_ev)
                flags[BIT_UNIT_EV] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else if (clk_en)
            irq <= |(flags & enables);
    end
endmodule : tcm_timer_unit

// file: tcm_timer_unit_checker.sv
// Purpose: port-level checks on the period timer and unit mode control
// Assumes: one clock domain; mode and enables are shadowed from bus writes
// Notes: attached to the design by the bind at the foot of this file
module tcm_timer_unit_checker
    import tcm_pkg::*;
(
    // clock, reset, enable
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    // ahb-lite slave
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // events out
    input wire logic        period_match_pulse,
    input wire logic        timer16_reset,
    input wire logic        converter_start,
    input wire logic        unit_pin,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_MODE = {22'h0, IDX_MODE, 2'h0};
    localparam logic [31:0] A_EN   = {22'h0, IDX_ENABLES, 2'h0};
    logic        take;
    logic        wr_q;
    logic        rd_mode_q;
    logic [31:0] a_q;
    logic [3:0]  mode_sh;
    logic [1:0]  en_sh;
    assign take = hready && hsel && htrans[1] && clk_en;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q      <= 1'b0;
            rd_mode_q <= 1'b0;
            a_q       <= 32'h0;
        end
        else if (clk_en)
        begin
            wr_q      <= take && hwrite;
            rd_mode_q <= take && !hwrite && haddr == A_MODE;
            a_q       <= haddr;
        end
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_sh <= M_OFF;
        else if (clk_en && wr_q && a_q == A_MODE)
            mode_sh <= hwdata[3:0];
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            en_sh <= 2'h0;
        else if (clk_en && wr_q && a_q == A_EN)
            en_sh <= hwdata[2:1];
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_pulse_gap;
        period_match_pulse |=> !period_match_pulse [*3];
    endproperty
    a_pulse_gap: assert property (p_pulse_gap)
        else $error("period match pulse too long or too close");
    property p_trig_pair;
        timer16_reset == converter_start;
    endproperty
    a_trig_pair: assert property (p_trig_pair)
        else $error("timer reset and converter start differ");
    property p_trig_one;
        $rose(timer16_reset) |=> !timer16_reset;
    endproperty
    a_trig_one: assert property (p_trig_one)
        else $error("special trigger longer than one cycle");
    property p_trig_mode;
        timer16_reset |-> mode_sh == M_CMP_TRIG;
    endproperty
    a_trig_mode: assert property (p_trig_mode)
        else $error("special trigger outside its mode");
    property p_sw_pin;
        mode_sh == M_CMP_SW && $past(mode_sh) == M_CMP_SW |-> $stable(unit_pin);
    endproperty
    a_sw_pin: assert property (p_sw_pin)
        else $error("unit pin moved in software interrupt mode");
    property p_off_pin;
        (mode_sh == M_OFF) [*3] |-> !unit_pin;
    endproperty
    a_off_pin: assert property (p_off_pin)
        else $error("unit pin high while unit is off");
    property p_mode_top;
        rd_mode_q |-> hrdata[7:6] == 2'b00;
    endproperty
    a_mode_top: assert property (p_mode_top)
        else $error("mode control top bits read nonzero");
    property p_irq_masked;
        (en_sh == 2'h0) [*2] |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt high while all enables clear");
    property p_okay;
        hreadyout && !hresp && hrdata[31:8] == 24'h0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not okay or wide read data");
    c_trig: cover property (timer16_reset);
    c_pulse: cover property (period_match_pulse ##1 !period_match_pulse);
    c_irq: cover property ($rose(irq));
    c_pin: cover property ($rose(unit_pin));
endmodule : tcm_timer_unit_checker

bind tcm_timer_unit tcm_timer_unit_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .period_match_pulse(period_match_pulse), .timer16_reset(timer16_reset),
    .converter_start(converter_start), .unit_pin(unit_pin), .irq(irq)
);

// file: tcm_timer_unit_tb.sv
// Purpose: register-level test of the period timer and unit mode control
// Assumes: zero-wait slave; the bench drives the sixteen-bit timer value
// Notes: period figures come from limit, prescale and the divide by four
module tcm_timer_unit_tb
    import tcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, cap, hreadyout, hresp;
    logic        pmp, t16_rst, conv, pin, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [15:0] t16;
    logic [7:0]  rv;
    int          n_errors, tests_run, gap;
    int          n_trig = 0;
    logic [31:0] ra [9] = '{'h30, 'h44, 'h48, 'h54, 'h58, 'h5C, 'h230, 'h248,
                            'h100};
    logic [7:0]  re [9] = '{0, 0, 0, 0, 0, 0, 0, 8'hFF, 0};
    logic [31:0] wa [11] = '{'h248, 'h54, 'h58, 'h230, 'h100, 'h5C, 'h5C,
                             'h48, 'h48, 'h248, 'h230};
    logic [7:0]  wd [11] = '{'hA5, 'h3C, 'hC3, 'hFF, 'hFF, 'hFF, 0, 'hFF, 0,
                             'hFF, 0};
    logic [7:0]  we [11] = '{'hA5, 'h3C, 'hC3, 'h06, 0, 'h3F, 0, 'h7F, 0,
                             'hFF, 0};
    logic [3:0]  cm [4] = '{M_CMP_CLR, M_CMP_SET, M_CMP_SW, M_CMP_TRIG};
    tcm_timer_unit uut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sixteen_bit_timer_count(t16),
        .capture_pin(cap), .period_match_pulse(pmp), .timer16_reset(t16_rst),
        .converter_start(conv), .unit_pin(pin), .irq(irq)
    );
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk)
        if (t16_rst === 1'b1 && conv === 1'b1) n_trig <= n_trig + 1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic wait_for(input logic which, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while ((which ? pmp : hreadyout) !== 1'b1 && n < lim);
        gap = n;
        if (n >= lim)
        begin
            n_errors++;
            $display("BAD t=%0t wait timed out", $time);
            tally_and_finish();
        end
    endtask : wait_for
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_for(1'b0, 50);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwrite <= 1'b0;
        hwdata <= {24'h0, d};
        wait_for(1'b0, 50);
        rv = hrdata[7:0];
    endtask : xfer
    task automatic rc(input logic [31:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rv, e);
        chk({7'h0, hresp}, 8'h00);
    endtask : rc
    initial
    begin
        {hresetn, hsel, hwrite, cap, htrans, haddr, hwdata, t16} = '0;
        {n_errors, tests_run} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 9; i++) rc(ra[i], re[i]);
        for (int i = 0; i < 11; i++)
        begin
            xfer(1'b1, wa[i], wd[i]);
            rc(wa[i], we[i]);
        end
        xfer(1'b1, 'h44, 8'h05);
        xfer(1'b1, 'h48, 8'h03);
        rc('h44, 8'h05);
        repeat (40) @(posedge hclk);
        rc('h44, 8'h05);
        xfer(1'b1, 'h48, 8'h04);
        repeat (40) @(posedge hclk);
        xfer(1'b0, 'h44, 8'h00);
        chk({7'h0, rv >= 8'h0D && rv <= 8'h11}, 8'h01);
        xfer(1'b1, 'h44, 8'h00);
        xfer(1'b1, 'h248, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            xfer(1'b1, 'h48, 8'h04 + 8'(i));
            wait_for(1'b1, 2000);
            wait_for(1'b1, 2000);
            chk({7'h0, gap == 16 << 2 * (i > 1 ? 2 : i)}, 8'h01);
        end
        repeat (100) @(posedge hclk);
        xfer(1'b1, 'h44, 8'h00);
        wait_for(1'b1, 2000);
        chk({7'h0, gap >= 250 && gap <= 262}, 8'h01);
        xfer(1'b1, 'h44, 8'h00);
        xfer(1'b1, 'h48, 8'h14);
        xfer(1'b1, 'h30, 8'h06);
        for (int k = 1; k < 4; k++)
        begin
            wait_for(1'b1, 2000);
            rc('h30, k == 3 ? 8'h02 : 8'h00);
        end
        chk({7'h0, irq}, 8'h00);
        xfer(1'b1, 'h230, 8'h02);
        repeat (2) @(posedge hclk);
        chk({7'h0, irq}, 8'h01);
        xfer(1'b1, 'h48, 8'h10);
        xfer(1'b1, 'h30, 8'h02);
        repeat (2) @(posedge hclk);
        chk({7'h0, irq}, 8'h00);
        xfer(1'b1, 'h54, 8'h34);
        xfer(1'b1, 'h58, 8'h12);
        for (int j = 0; j < 4; j++)
        begin
            xfer(1'b1, 'h30, 8'h04);
            xfer(1'b1, 'h5C, {4'h0, cm[j]});
            t16 <= 16'h1234;
            repeat (4) @(posedge hclk);
            chk({7'h0, pin}, j == 0 ? 8'h00 : 8'h01);
            rc('h30, 8'h04);
            chk(8'(n_trig), j == 3 ? 8'h01 : 8'h00);
            t16 <= 16'h0000;
        end
        xfer(1'b1, 'h5C, 8'h00);
        repeat (2) @(posedge hclk);
        chk({7'h0, pin}, 8'h00);
        for (int j = 0; j < 2; j++)
        begin
            xfer(1'b1, 'h30, 8'h04);
            xfer(1'b1, 'h5C, j == 0 ? {4'h0, M_CAP_RISE} : {4'h0, M_CAP_FALL});
            t16 <= j == 0 ? 16'hBEEF : 16'h1357;
            cap <= ~cap;
            repeat (8) @(posedge hclk);
            rc('h54, j == 0 ? 8'hEF : 8'h57);
            rc('h58, j == 0 ? 8'hBE : 8'h13);
            rc('h30, 8'h04);
        end
        xfer(1'b1, 'h54, 8'h01);
        xfer(1'b1, 'h5C, 8'h0C);
        xfer(1'b1, 'h48, 8'h04);
        wait_for(1'b1, 2000);
        chk({7'h0, pin}, 8'h01);
        repeat (8) @(posedge hclk);
        chk({7'h0, pin}, 8'h00);
        rc('h58, 8'h01);
        tally_and_finish();
    end
endmodule : tcm_timer_unit_tb
